// ==== logic/crs_pkg.sv ====
// crs_pkg: register map, field positions and reset values of the reset-state register bank
// assumes a 32-bit axi4-lite slave with one aligned word per register
`default_nettype none
package crs_pkg;
  localparam int CRS_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_PRIV_BASE  = 8'h00;
  localparam logic [7:0] OFS_IBOX       = 8'h04;
  localparam logic [7:0] OFS_LSU        = 8'h08;
  localparam logic [7:0] OFS_BIU        = 8'h0C;
  localparam logic [7:0] OFS_PCNT0      = 8'h10;
  localparam logic [7:0] OFS_PCNT1      = 8'h14;
  localparam logic [7:0] OFS_CYC        = 8'h18;
  localparam logic [7:0] OFS_PSTAT      = 8'h1C;
  localparam logic [7:0] OFS_SERIAL     = 8'h20;
  localparam logic [7:0] OFS_TLB_SEL    = 8'h24;
  localparam logic [7:0] OFS_ITLB_INV   = 8'h28;
  localparam logic [7:0] OFS_DTLB_INV   = 8'h2C;
  localparam logic [7:0] OFS_EXC_SUMMARY = 8'h30;
  localparam logic [7:0] OFS_INIT_STAT  = 8'h34;
  localparam logic [7:0] OFS_EVENTS     = 8'h38;
  // ibox_control_status fields
  localparam int IB_FPE     = 0;
  localparam int IB_DUAL    = 1;
  localparam int IB_PIPE_DIS = 2;
  localparam int IB_JSR     = 3;
  localparam int IB_BPE     = 4;
  localparam int IB_BHT     = 5;
  localparam int IB_SPAGE   = 6;
  localparam int IB_PC0_LO  = 8;
  localparam int IB_PC1_LO  = 12;
  localparam logic [3:0] PC0_SEL_ISSUE_DIV2 = 4'h0;
  localparam logic [3:0] PC1_SEL_DCACHE_MISS = 4'h0;
  localparam logic [31:0] IBOX_RESET = 32'h0000_0000;
  // load_store_unit_control fields
  localparam int LS_WB_DIS   = 0;
  localparam int LS_MCHK     = 1;
  localparam int LS_CRD      = 2;
  localparam int LS_ISTREAM  = 3;
  localparam int LS_SPAGE1   = 4;
  localparam int LS_SPAGE2   = 5;
  localparam int LS_ENDIAN   = 6;
  localparam int LS_DC_EN    = 7;
  localparam int LS_FHIT     = 8;
  localparam int LS_STC_NR   = 9;
  localparam int LS_NC_ND    = 10;
  localparam logic [31:0] LSU_RESET = 32'h0000_0000;
  // bus_interface_control fields
  localparam int BI_BC_EN    = 0;
  localparam int BI_ECC      = 1;
  localparam int BI_OE_MODE  = 2;
  localparam int BI_BC_FHIT  = 3;
  localparam int BI_FBAD_TAG = 4;
  localparam int BI_FBAD_DAT = 5;
  localparam int BI_DLY_WD   = 6;
  localparam int BI_WRAP_ORD = 7;
  localparam int BI_PADIS_LO = 8;
  localparam int BI_RD_LO    = 12;
  localparam int BI_WR_LO    = 16;
  localparam int BI_WE_LO    = 20;
  localparam int BI_SIZE_LO  = 24;
  // fields cleared on reset; speed, shape and size keep whatever they held
  localparam logic [31:0] BIU_CLR_MASK = 32'h0000_0FFF;
  localparam logic [31:0] PRIV_BASE_RESET = 32'h0000_0000;
  localparam logic [6:0]  EXC_READS_NEEDED = 7'h40;
  localparam logic [1:0]  AXI_OKAY   = 2'b00;
  localparam logic [1:0]  AXI_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ==== logic/crs_event_cnt.sv ====
// crs_event_cnt: 32-bit event counter with clear and software load
// assumes increment strobes synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module crs_event_cnt #(
  parameter int W = 32
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         clr,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         inc,
  output logic      [W-1:0] count
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // clear or load wins over a same-cycle increment
  assign count_d = clr ? '0 : load ? load_val : inc ? count_q + W'(1) : count_q;
  assign count   = count_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule
`default_nettype wire

// ==== logic/crs_regbank.sv ====
// crs_regbank: processor control register bank with documented reset states, axi4-lite slave
// assumes event strobes from the core synchronous to aclk; bus master obeys axi4-lite
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE_01] reset clears the privileged code base register to zero
// [RULE_02] reset disables jsr prediction, branch prediction and branch history table
// [RULE_03] reset zeroes both counters; selects issues/2 and dcache misses
// [RULE_04] reset disables fp, single issue, pipelined mode on, superpage off
// [RULE_05] reset clears lsu control: write buffer on, mchk, crd, stream buffer off
// [RULE_06] lsu reset leaves superpages 1,2, alt endian, dcache, forced hit off
// [RULE_07] lsu reset disables store-conditional no-result and noncached no-disturb
// [RULE_08] reset clears bus control: bcache off, parity, ce on write, no forced hit
// [RULE_09] reset clears region disable, bad parity controls, delayed write, system wrap
// [RULE_10] cycle counter held disabled after reset; value undefined until set
// [RULE_11] firmware invalidates itlb before loading any itlb entry
// [RULE_12] firmware invalidates dtlb before loading any dtlb entry
// [RULE_13] firmware clears exception summary by reading it 64 times
// [RULE_14] firmware selects tlb page size before any tlb fill
// [RULE_15] firmware sets processor status, undefined at reset
// [RULE_16] serial transmit undefined at reset drives a pin; firmware initialises it
// [RULE_17] firmware programs bcache speed, shape, size before enabling bcache
// [RULE_18] undefined-at-reset registers are not driven by hardware reset
module crs_regbank
  import crs_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [CRS_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [CRS_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              issue_event,
  input  wire logic              dcache_miss_event,
  input  wire logic              exception_event,
  output logic [31:0]            ibox_control_status,
  output logic [31:0]            load_store_unit_control,
  output logic [31:0]            bus_interface_control,
  output logic [31:0]            privileged_code_base,
  output logic                   serial_line_transmit,
  output logic                   tlb_page_size_select,
  output logic                   itlb_invalidate_all,
  output logic                   dtlb_invalidate_all
);
  logic [31:0] priv_base_q;
  logic [31:0] ibox_q;
  logic [31:0] lsu_q;
  logic [31:0] biu_q;
  logic [31:0] pstat_q;
  logic        serial_q;
  logic        tlb_sel_q;
  logic        itlb_inv_q;
  logic        dtlb_inv_q;
  logic        itlb_done_q;
  logic        dtlb_done_q;
  logic        tlb_sel_done_q;
  logic        pstat_done_q;
  logic        serial_done_q;
  logic        cyc_en_q;
  logic [31:0] cyc_q;
  logic [31:0] exc_summary_q;
  logic [6:0]  exc_reads_q;
  logic        issue_half_q;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // write side: each channel latched independently, executed when both are held
  wire         aw_take  = s_axi_awvalid && !aw_hold_q && !bvalid_q;
  wire         w_take   = s_axi_wvalid && !w_hold_q && !bvalid_q;
  wire         wr_go    = aw_hold_q && w_hold_q && !bvalid_q;
  wire [31:0]  wmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
                           {8{w_strb_q[0]}}};
  wire [7:0]   wa       = {aw_addr_q[7:2], 2'b00};
  wire         wr_pbase = wr_go && wa == OFS_PRIV_BASE;
  wire         wr_ibox  = wr_go && wa == OFS_IBOX;
  wire         wr_lsu   = wr_go && wa == OFS_LSU;
  wire         wr_biu   = wr_go && wa == OFS_BIU;
  wire         wr_pc0   = wr_go && wa == OFS_PCNT0;
  wire         wr_pc1   = wr_go && wa == OFS_PCNT1;
  wire         wr_cyc   = wr_go && wa == OFS_CYC;
  wire         wr_pstat = wr_go && wa == OFS_PSTAT;
  wire         wr_ser   = wr_go && wa == OFS_SERIAL;
  wire         wr_tsel  = wr_go && wa == OFS_TLB_SEL;
  wire         wr_iinv  = wr_go && wa == OFS_ITLB_INV;
  wire         wr_dinv  = wr_go && wa == OFS_DTLB_INV;
  wire         wr_cyc_en = wr_go && wa == OFS_INIT_STAT;
  wire         wr_hit   = wr_pbase || wr_ibox || wr_lsu || wr_biu || wr_pc0 || wr_pc1 ||
                          wr_cyc || wr_pstat || wr_ser || wr_tsel || wr_iinv || wr_dinv ||
                          wr_cyc_en;
  wire [31:0]  wmerge_ibox = (ibox_q & ~wmask) | (w_data_q & wmask);
  wire [31:0]  wmerge_lsu  = (lsu_q & ~wmask) | (w_data_q & wmask);
  wire [31:0]  wmerge_biu  = (biu_q & ~wmask) | (w_data_q & wmask);
  wire [31:0]  wmerge_pb   = (priv_base_q & ~wmask) | (w_data_q & wmask);
  wire [31:0]  wmerge_pstat = (pstat_q & ~wmask) | (w_data_q & wmask);
  wire [31:0]  wmerge_cyc  = (cyc_q & ~wmask) | (w_data_q & wmask);

  // read side
  wire         ar_take  = s_axi_arvalid && !rvalid_q;
  wire [7:0]   ra       = {s_axi_araddr[7:2], 2'b00};
  wire [31:0]  pc0_val;
  wire [31:0]  pc1_val;
  wire         rd_exc   = ar_take && ra == OFS_EXC_SUMMARY;
  wire [31:0]  init_stat = {26'h000_0000, cyc_en_q, serial_done_q, pstat_done_q,
                            tlb_sel_done_q, dtlb_done_q, itlb_done_q};
  wire [31:0]  events    = {25'h000_0000, exc_reads_q};
  logic [31:0] rd_mux;
  logic        rd_ok;

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (ra)
      OFS_PRIV_BASE: rd_mux = priv_base_q;
      OFS_IBOX:      rd_mux = ibox_q;
      OFS_LSU:       rd_mux = lsu_q;
      OFS_BIU:       rd_mux = biu_q;
      OFS_PCNT0:     rd_mux = pc0_val;
      OFS_PCNT1:     rd_mux = pc1_val;
      OFS_CYC:       rd_mux = cyc_q;
      OFS_PSTAT:     rd_mux = pstat_q;
      OFS_SERIAL:    rd_mux = {31'h0000_0000, serial_q};
      OFS_TLB_SEL:   rd_mux = {31'h0000_0000, tlb_sel_q};
      OFS_EXC_SUMMARY: rd_mux = exc_summary_q;
      OFS_INIT_STAT: rd_mux = init_stat;
      OFS_EVENTS:    rd_mux = events;
      default:       rd_ok  = 1'b0;
    endcase
  end

  // counter 0 advances once per two issues
  wire pc0_inc = issue_event && issue_half_q
                 && ibox_q[IB_PC0_LO +: 4] == PC0_SEL_ISSUE_DIV2;                 // [RULE_03]
  wire pc1_inc = dcache_miss_event
                 && ibox_q[IB_PC1_LO +: 4] == PC1_SEL_DCACHE_MISS;                // [RULE_03]

  crs_event_cnt #(.W(32)) u_pc0 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (1'b0),
    .load     (wr_pc0),
    .load_val (w_data_q),
    .inc      (pc0_inc),
    .count    (pc0_val)
  );

  crs_event_cnt #(.W(32)) u_pc1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (1'b0),
    .load     (wr_pc1),
    .load_val (w_data_q),
    .inc      (pc1_inc),
    .count    (pc1_val)
  );

  // control registers with defined reset states
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      priv_base_q  <= PRIV_BASE_RESET;                                           // [RULE_01]
      ibox_q       <= IBOX_RESET;                                  // [RULE_02] [RULE_04]
      lsu_q        <= LSU_RESET;                        // [RULE_05] [RULE_06] [RULE_07]
      issue_half_q <= 1'b0;
      cyc_en_q     <= 1'b0;                                                      // [RULE_10]
    end else begin
      if (wr_pbase) priv_base_q <= wmerge_pb;
      if (wr_ibox) ibox_q <= wmerge_ibox;
      if (wr_lsu) lsu_q <= wmerge_lsu;
      if (wr_cyc_en) cyc_en_q <= w_data_q[5];
      if (issue_event) issue_half_q <= !issue_half_q;
    end
  end

  // bus control: reset clears only the low control fields, timing fields keep whatever they held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      biu_q <= biu_q & ~BIU_CLR_MASK;                                  // [RULE_08] [RULE_09]
    end else if (wr_biu) begin
      biu_q <= wmerge_biu;
    end
  end

  // registers left undefined by reset: no reset term at all, they stay x until written
  always_ff @(posedge aclk) begin
    if (wr_pstat) begin
      pstat_q <= wmerge_pstat;                                   // [RULE_18]
    end
  end

  // the pin carries x until firmware writes the bit; nothing here forces a level
  always_ff @(posedge aclk) begin
    if (wr_ser && w_strb_q[0]) begin
      serial_q <= w_data_q[0];                                   // [RULE_16]
    end
  end

  // page size choice is only trusted once firmware has made it before the first fill
  always_ff @(posedge aclk) begin
    if (wr_tsel && w_strb_q[0]) begin
      tlb_sel_q <= w_data_q[0];
    end
  end

  // a software write wins over the running increment in the same cycle
  always_ff @(posedge aclk) begin
    if (wr_cyc) begin
      cyc_q <= wmerge_cyc;
    end else if (cyc_en_q) begin
      cyc_q <= cyc_q + 32'h0000_0001;                            // [RULE_10]
    end
  end

  // exception summary: an arriving exception wins over the read-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exc_reads_q <= 7'h00;
    end else if (rd_exc && exc_reads_q != EXC_READS_NEEDED) begin
      exc_reads_q <= exc_reads_q + 7'h01;                                        // [RULE_13]
    end
  end

  always_ff @(posedge aclk) begin
    if (exception_event) exc_summary_q <= {exc_summary_q[30:0], 1'b1};
    else if (rd_exc) exc_summary_q <= 32'h0000_0000;
  end

  // invalidate strobes: one-cycle pulses, dropped again at the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      itlb_inv_q <= 1'b0;
      dtlb_inv_q <= 1'b0;
    end else begin
      itlb_inv_q <= wr_iinv;                                                     // [RULE_11]
      dtlb_inv_q <= wr_dinv;                                                     // [RULE_12]
    end
  end

  // init progress flags: sticky until the next reset so firmware can audit its own bring-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      itlb_done_q    <= 1'b0;
      dtlb_done_q    <= 1'b0;
      tlb_sel_done_q <= 1'b0;
      pstat_done_q   <= 1'b0;
      serial_done_q  <= 1'b0;
    end else begin
      if (wr_iinv) itlb_done_q <= 1'b1;
      if (wr_dinv) dtlb_done_q <= 1'b1;
      if (wr_tsel) tlb_sel_done_q <= 1'b1;                                       // [RULE_14]
      if (wr_pstat) pstat_done_q <= 1'b1;                                        // [RULE_15]
      if (wr_ser) serial_done_q <= 1'b1;
    end
  end

  // axi4-lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= AXI_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= AXI_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_ok ? rd_mux : 32'h0000_0000;
      rresp_q  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = aw_take;
  assign s_axi_wready  = w_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ar_take;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // bcache enable is only meaningful once firmware has set its timing fields
  assign ibox_control_status     = ibox_q;
  assign load_store_unit_control = lsu_q;
  assign bus_interface_control   = biu_q;                                        // [RULE_17]
  assign privileged_code_base    = priv_base_q;
  assign serial_line_transmit    = serial_q;
  assign tlb_page_size_select    = tlb_sel_q;
  assign itlb_invalidate_all     = itlb_inv_q;
  assign dtlb_invalidate_all     = dtlb_inv_q;
endmodule
`default_nettype wire

// ==== dv/crs_regbank_chk.sv ====
// crs_regbank_chk: port-level assertions for the reset-state register bank
// assumes a bind onto crs_regbank; one aclk domain, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module crs_regbank_chk
  import crs_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [CRS_AW-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [CRS_AW-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic [31:0]       ibox_control_status,
  input wire logic [31:0]       load_store_unit_control,
  input wire logic [31:0]       bus_interface_control,
  input wire logic [31:0]       privileged_code_base,
  input wire logic              itlb_invalidate_all,
  input wire logic              dtlb_invalidate_all
);
  default clocking cb @(posedge aclk); endclocking
  // both channels taken at one edge: the write executes on the next edge
  sequence s_wr_taken(logic [CRS_AW-1:0] a);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == a;
  endsequence
  sequence s_one_pulse(logic p);
    p ##1 !p;
  endsequence
  property p_rst_base;  !aresetn |=> privileged_code_base == PRIV_BASE_RESET; endproperty
  property p_rst_ibox;  !aresetn |=> ibox_control_status == IBOX_RESET; endproperty
  property p_rst_lsu;   !aresetn |=> load_store_unit_control == LSU_RESET; endproperty
  property p_rst_biu;   !aresetn |=> (bus_interface_control & BIU_CLR_MASK) == 32'h0000_0000;
  endproperty
  property p_rst_resp;  !aresetn |=> !s_axi_bvalid && !s_axi_rvalid; endproperty
  property p_itlb;
    disable iff (!aresetn) s_wr_taken(OFS_ITLB_INV) |-> ##[1:3] s_one_pulse(itlb_invalidate_all);
  endproperty
  property p_dtlb;
    disable iff (!aresetn) s_wr_taken(OFS_DTLB_INV) |-> ##[1:3] s_one_pulse(dtlb_invalidate_all);
  endproperty
  property p_wr_lat;
    disable iff (!aresetn) s_wr_taken(s_axi_awaddr)
      |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  // the low two address bits do not select a register, so compare word addresses
  property p_rd_unmapped;
    disable iff (!aresetn) s_axi_arvalid && s_axi_arready
      && (s_axi_araddr | 8'h03) > (OFS_EVENTS | 8'h03)
      |=> s_axi_rvalid && s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_rst_base: assert property (p_rst_base) else $error("base not cleared");
  a_rst_ibox: assert property (p_rst_ibox) else $error("ibox not reset");
  a_rst_lsu: assert property (p_rst_lsu) else $error("lsu reset");
  a_rst_biu: assert property (p_rst_biu) else $error("biu reset");
  a_rst_resp:    assert property (p_rst_resp) else $error("response valid after reset");
  a_itlb: assert property (p_itlb) else $error("itlb invalidate pulse wrong");
  a_dtlb: assert property (p_dtlb) else $error("dtlb invalidate pulse wrong");
  a_wr_lat:      assert property (p_wr_lat) else $error("write response timing wrong");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
endmodule
bind crs_regbank crs_regbank_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .ibox_control_status,
  .load_store_unit_control, .bus_interface_control, .privileged_code_base,
  .itlb_invalidate_all, .dtlb_invalidate_all);
`default_nettype wire

// ==== dv/tb.sv ====
// tb: self-checking bench for crs_regbank through its axi4-lite port
// assumes crs_pkg offsets; bready/rready stay high so every response drains at once
`timescale 1ns/1ps
`default_nettype none
module tb
  import crs_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} crs_exp_type;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, issue_event, dcache_miss_event, exception_event;
  logic        serial_line_transmit, tlb_page_size_select;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ibox_control_status, load_store_unit_control;
  logic [31:0] bus_interface_control, privileged_code_base, wv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [19:0] hi;
  crs_exp_type rq[$];
  crs_exp_type e_r;
  logic [1:0]  bq[$];
  int          n_errors, cmp_count, cyc, k, m;

  crs_regbank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .issue_event, .dcache_miss_event,
    .exception_event, .ibox_control_status, .load_store_unit_control, .bus_interface_control,
    .privileged_code_base, .serial_line_transmit, .tlb_page_size_select,
    .itlb_invalidate_all(), .dtlb_invalidate_all());

  always #5 aclk = ~aclk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // response monitor: oldest note is matched against each response as it appears
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      e_r = rq.pop_front();
      cmp_val("rdata", e_r.d & e_r.m, s_axi_rdata & e_r.m);
      cmp_val("rresp", {30'h0, e_r.r}, {30'h0, s_axi_rresp});
    end
    if (aresetn && s_axi_bvalid && s_axi_bready) cmp_val("bresp", {30'h0, bq.pop_front()},
      {30'h0, s_axi_bresp});
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] msk,
                    input logic [1:0] r);
    rq.push_back('{d, msk, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // upper bus-control bits are checked for surviving reset only where a value is known (hm set)
  task automatic check_reset(input logic [19:0] h, input logic [19:0] hm);
    rd(OFS_PRIV_BASE, 32'h0000_0000, ALL, AXI_OKAY);
    rd(OFS_IBOX, IBOX_RESET, ALL, AXI_OKAY);
    rd(OFS_LSU, LSU_RESET, ALL, AXI_OKAY);
    rd(OFS_BIU, {h, 12'h000}, {hm, 12'hFFF}, AXI_OKAY);
    rd(OFS_PCNT0, 32'h0000_0000, ALL, AXI_OKAY);
    rd(OFS_PCNT1, 32'h0000_0000, ALL, AXI_OKAY);
    rd(OFS_INIT_STAT, 32'h0000_0000, 32'h0000_0020, AXI_OKAY);
  endtask

  initial begin
    void'($urandom(32'hc03c7dc0));
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {issue_event, dcache_miss_event, exception_event, cyc, n_errors, cmp_count} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    do_reset();
    check_reset(20'h0_0000, 20'h0_0000);
    k = $urandom_range(38, 2);
    m = $urandom_range(38, 1);
    for (int i = 0; i < 40; i++) begin
      issue_event <= (i < k);
      dcache_miss_event <= (i < m);
      @(posedge aclk);
    end
    rd(OFS_PCNT0, 32'(k / 2), ALL, AXI_OKAY);
    rd(OFS_PCNT1, 32'(m), ALL, AXI_OKAY);
    wr(OFS_ITLB_INV, $urandom, AXI_OKAY);
    wr(OFS_DTLB_INV, $urandom, AXI_OKAY);
    wr(OFS_TLB_SEL, 32'h0000_0001, AXI_OKAY);
    wr(OFS_PSTAT, $urandom, AXI_OKAY);
    wv = $urandom;
    wr(OFS_SERIAL, wv, AXI_OKAY);
    cmp_val("serial", {31'h0, wv[0]}, {31'h0, serial_line_transmit});
    cmp_val("tlbsel", 32'h0000_0001, {31'h0, tlb_page_size_select});
    rd(OFS_INIT_STAT, 32'h0000_001F, 32'h0000_001F, AXI_OKAY);
    // the write-only itlb invalidate register refuses reads
    rd(OFS_ITLB_INV, 32'h0000_0000, ALL, AXI_SLVERR);
    rd(OFS_EXC_SUMMARY, 32'h0000_0000, 32'h0000_0000, AXI_OKAY);
    repeat (64) rd(OFS_EXC_SUMMARY, 32'h0000_0000, ALL, AXI_OKAY);
    rd(OFS_EVENTS, {25'h0, EXC_READS_NEEDED}, ALL, AXI_OKAY);
    exception_event <= 1'b1;
    @(posedge aclk);
    exception_event <= 1'b0;
    rd(OFS_EXC_SUMMARY, 32'h0000_0001, ALL, AXI_OKAY);
    wr(8'h3C, $urandom, AXI_SLVERR);
    rd(8'h3C, 32'h0000_0000, ALL, AXI_SLVERR);
    hi = 20'($urandom);
    // speeds, shape and size go in before the enable bit, then again unchanged together with it
    wr(OFS_BIU, {hi, 12'h000}, AXI_OKAY);
    wr(OFS_BIU, {hi, 12'h0FF}, AXI_OKAY);
    rd(OFS_BIU, {hi, 12'h0FF}, ALL, AXI_OKAY);
    wr(OFS_IBOX, $urandom | 32'h0000_0001, AXI_OKAY);
    wr(OFS_LSU, $urandom | 32'h0000_0001, AXI_OKAY);
    wv = $urandom | 32'h0001_0000;
    wr(OFS_PRIV_BASE, wv, AXI_OKAY);
    rd(OFS_PRIV_BASE, wv, ALL, AXI_OKAY);
    wr(OFS_INIT_STAT, 32'h0000_0020, AXI_OKAY);
    rd(OFS_INIT_STAT, 32'h0000_0020, 32'h0000_0020, AXI_OKAY);
    do_reset();
    check_reset(hi, 20'hF_FFFF);
    // a disabled cycle counter keeps the value software wrote
    wv = $urandom;
    wr(OFS_CYC, wv, AXI_OKAY);
    rd(OFS_CYC, wv, ALL, AXI_OKAY);
    summarize();
  end
endmodule
`default_nettype wire
